// [core/esr_pkg.sv]
// Constants and types for the exception state readback block.
// Assumes one 20 MHz clock and a plain strobe register port.
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
// Behaviour
// - Bits 17:12 show best pending enabled exception
// - Apply threshold and fault mask, ignore priority mask
// - 0 none, 2 to 6 NMI and faults
// - 0x0B, 0x0E, 0x0F; other low codes reserved
// - Vectors report as 0x10 upward to 0x3B
// - Bit 11 low while preempted exceptions wait
// - Bit 11 counts ordinary interrupts only
// - Bits 10:6 reserved, read zero
// - Bits 5:0 show active exception number
// - Active field zero in thread mode
// - Active field equals program status number
package esr_pkg;

    // Register word offsets (byte addresses)
    localparam logic [7:0] ESR_OFS_ICS = 8'h00; // Interrupt control state
    localparam logic [7:0] ESR_OFS_MASK = 8'h04; // Threshold and fault mask

    // Field positions in the interrupt control state word
    localparam int ESR_POS_PEND = 12;
    localparam int ESR_POS_RETB = 11;
    localparam int ESR_POS_ACT = 0;

    // Field positions in the mask word
    localparam int ESR_POS_FMASK = 0;
    localparam int ESR_POS_BPRI = 5;

    // Reset values
    localparam logic [31:0] ESR_RST_WORD = 32'h0000_0000;
    localparam logic [5:0] ESR_RST_NUM = 6'h00;

    // Exception numbers
    localparam logic [5:0] ESR_EXC_NONE = 6'h00;
    localparam logic [5:0] ESR_EXC_NMI = 6'h02;
    localparam logic [5:0] ESR_EXC_HARD = 6'h03;
    localparam logic [5:0] ESR_EXC_MEM = 6'h04;
    localparam logic [5:0] ESR_EXC_USAGE = 6'h06;
    localparam logic [5:0] ESR_EXC_SVC = 6'h0B;
    localparam logic [5:0] ESR_EXC_PSV = 6'h0E;
    localparam logic [5:0] ESR_EXC_TICK = 6'h0F;
    localparam logic [5:0] ESR_EXC_VEC0 = 6'h10;
    localparam logic [5:0] ESR_EXC_VMAX = 6'h3B;
    localparam int ESR_VEC_BASE = 16; // Subtracted by software for the vector index

    // Priority levels: two fixed ones, then offset for programmable
    localparam logic [3:0] ESR_LVL_NMI = 4'h0;
    localparam logic [3:0] ESR_LVL_HARD = 4'h1;
    localparam logic [3:0] ESR_LVL_OFS = 4'h2;
    localparam logic [3:0] ESR_LVL_IDLE = 4'hF;

    // Read-only status fields
    typedef struct packed {
        logic [5:0] pend; // pending_exception_number
        logic retb; // return_to_base_flag
        logic [5:0] act; // active_exception_number
    } esr_ics_s;

    // Software-written masking state
    typedef struct packed {
        logic [2:0] bpri; // base_priority_threshold, implemented bits
        logic fmask; // fault_mask_register
    } esr_mask_s;

endpackage : esr_pkg

// [core/esr_readback.sv]
// Exception state readback: pending, return-to-base and active fields.
// Assumes the exception controller supplies pending, enable, active,
// priority and program status state, synchronous to i_clk_sys.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps

module esr_readback #(
    parameter int NUM_VEC = 44 // Peripheral vectors implemented
) (
    input wire logic i_clk_sys, // 20 MHz system clock
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic [7:0] i_addr, // Register byte address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, cycle after i_rd
    input wire logic [63:0] i_exc_pend, // Pending per exception number
    input wire logic [63:0] i_exc_enab, // Enable per exception number
    input wire logic [63:0] i_exc_actv, // Active per exception number
    input wire logic [63:0][2:0] i_exc_prio, // Group priority per number
    input wire logic [5:0] i_psr_num, // interrupt_program_status number
    output esr_pkg::esr_ics_s o_ics // Registered status fields
);
    import esr_pkg::*;

    //--------------------------------------------------------
    // Elaboration checks
    //--------------------------------------------------------
    // Codes above 0x3B are reserved, so more vectors cannot be shown
    if (NUM_VEC < 1 || NUM_VEC > 44) begin : g_bad_vec
        $error("NUM_VEC must lie in 1..44");
    end

    //--------------------------------------------------------
    // Helpers
    //--------------------------------------------------------
    // True for codes that name a real exception on this part
    function automatic logic is_legal(input logic [5:0] num);
        logic ok;
        ok = 1'b0;
        if (num >= ESR_EXC_NMI && num <= ESR_EXC_USAGE) begin
            ok = 1'b1;
        end
        if (num == ESR_EXC_SVC || num == ESR_EXC_PSV || num == ESR_EXC_TICK) begin
            ok = 1'b1;
        end
        if (num >= ESR_EXC_VEC0 && 32'(num) < ESR_VEC_BASE + NUM_VEC) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : is_legal

    // True for numbers that count toward return-to-base
    function automatic logic is_ordinary(input logic [5:0] num);
        return is_legal(num) && num > ESR_EXC_USAGE;
    endfunction : is_ordinary

    // Lowest level wins; ties go to the lower number
    function automatic logic [5:0] pick_best(input logic [63:0] cand,
                                             input logic [63:0][3:0] lvl);
        logic [5:0] best;
        logic [3:0] best_lvl;
        best = ESR_EXC_NONE;
        best_lvl = ESR_LVL_IDLE;
        for (int i = 63; i >= 1; i--) begin
            if (cand[i] && lvl[i] <= best_lvl) begin
                best = 6'(i);
                best_lvl = lvl[i];
            end
        end
        return best;
    endfunction : pick_best

    //--------------------------------------------------------
    // Mask register
    //--------------------------------------------------------
    esr_mask_s mask_q; // Threshold and fault mask held for software
    esr_mask_s mask_d; // Next mask value

    // Next mask: only a write to its own offset changes it
    always_comb begin
        mask_d = mask_q;
        if (i_wr && i_addr == ESR_OFS_MASK) begin
            mask_d.fmask = i_wdata[ESR_POS_FMASK];
            mask_d.bpri = i_wdata[ESR_POS_BPRI +: 3];
        end
    end

    // Mask register flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mask_q <= '0;
        end else begin
            mask_q <= mask_d;
        end
    end

    //--------------------------------------------------------
    // Pending selection
    //--------------------------------------------------------
    logic [63:0][3:0] lvl; // Effective level per number
    logic [63:0] cand; // Pending, enabled, legal and not masked
    logic [5:0] best; // Winning number this cycle

    // Candidates; the priority mask is not an input on purpose,
    // since the reported number must not depend on it
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            lvl[i] = 4'(i_exc_prio[i]) + ESR_LVL_OFS;
            cand[i] = i_exc_pend[i] && i_exc_enab[i] && is_legal(6'(i));
            // Threshold masks programmable levels at or above it
            if (mask_q.bpri != 3'h0 && i_exc_prio[i] >= mask_q.bpri) begin
                cand[i] = 1'b0;
            end
            // Fault mask leaves only the non-maskable interrupt
            if (mask_q.fmask && 6'(i) != ESR_EXC_NMI) begin
                cand[i] = 1'b0;
            end
        end
        // Fixed levels, and these two cannot be disabled
        lvl[ESR_EXC_NMI] = ESR_LVL_NMI;
        lvl[ESR_EXC_HARD] = ESR_LVL_HARD;
        cand[ESR_EXC_NMI] = i_exc_pend[ESR_EXC_NMI];
        cand[ESR_EXC_HARD] = i_exc_pend[ESR_EXC_HARD] && !mask_q.fmask;
        best = pick_best(cand, lvl);
    end

    //--------------------------------------------------------
    // Return-to-base
    //--------------------------------------------------------
    logic others_actv; // Some other ordinary exception is active

    // Preempted work exists when an ordinary exception other than
    // the executing one is active; faults and NMI are left out
    always_comb begin
        others_actv = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (i_exc_actv[i] && is_ordinary(6'(i)) && 6'(i) != i_psr_num) begin
                others_actv = 1'b1;
            end
        end
    end

    //--------------------------------------------------------
    // Status register
    //--------------------------------------------------------
    esr_ics_s ics_q; // Registered status fields
    esr_ics_s ics_d; // Next status fields

    // Status follows controller state and the mask register, never a bus write
    always_comb begin
        ics_d.pend = best;
        ics_d.retb = !others_actv;
        // Thread mode has program status zero, so this reads zero
        ics_d.act = i_psr_num;
    end

    // Status flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ics_q <= '{pend: ESR_RST_NUM, retb: 1'b1, act: ESR_RST_NUM};
        end else begin
            ics_q <= ics_d;
        end
    end

    assign o_ics = ics_q;

    //--------------------------------------------------------
    // Read port
    //--------------------------------------------------------
    logic [31:0] rdata_q; // Read data register
    logic [31:0] rdata_d; // Next read data
    logic [31:0] ics_word; // Status packed into its word

    // Pack status; reserved bits stay zero
    always_comb begin
        ics_word = ESR_RST_WORD;
        ics_word[ESR_POS_PEND +: 6] = ics_q.pend;
        ics_word[ESR_POS_RETB] = ics_q.retb;
        ics_word[ESR_POS_ACT +: 6] = ics_q.act;
    end

    // Decode; unmapped offsets read zero, data stands one cycle
    always_comb begin
        rdata_d = ESR_RST_WORD;
        if (i_rd) begin
            unique case (i_addr)
                ESR_OFS_ICS: begin
                    rdata_d = ics_word;
                end
                ESR_OFS_MASK: begin
                    rdata_d[ESR_POS_FMASK] = mask_q.fmask;
                    rdata_d[ESR_POS_BPRI +: 3] = mask_q.bpri;
                end
                default: begin
                    rdata_d = ESR_RST_WORD;
                end
            endcase
        end
    end

    // Read data flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= ESR_RST_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    //--------------------------------------------------------
    // Assertions
    //--------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // A read strobe at the status offset; its data is checked by s_ics_data
    sequence s_ics_read;
        i_rd && i_addr == ESR_OFS_ICS;
    endsequence

    // The word is captured at the strobe edge, so compare with the word
    // that stood then; status may already have moved on
    sequence s_ics_data;
        ##1 o_rdata == $past(ics_word);
    endsequence

    pend_field_a: assert property (##1 o_ics.pend == $past(best))
        else $error("pending field does not follow selection");

    fault_mask_a: assert property (mask_q.fmask |=>
        (o_ics.pend == ESR_EXC_NONE || o_ics.pend == ESR_EXC_NMI))
        else $error("fault mask let a maskable exception through");

    pend_none_a: assert property ((cand == 64'h0000_0000_0000_0000) |=>
        o_ics.pend == ESR_EXC_NONE)
        else $error("pending field not zero with nothing pending");

    reserved_code_a: assert property (is_legal(o_ics.pend) || o_ics.pend == ESR_EXC_NONE)
        else $error("reserved code reported as pending");

    vector_range_a: assert property (o_ics.pend <= ESR_EXC_VMAX)
        else $error("pending code above last vector");

    ret_base_a: assert property (##1 o_ics.retb == !$past(others_actv))
        else $error("return-to-base flag wrong");

    ics_reserved_a: assert property (s_ics_read |=> o_rdata[10:6] == 5'h00)
        else $error("reserved bits read non-zero");

    act_follow_a: assert property (##1 o_ics.act == $past(i_psr_num))
        else $error("active field differs from program status");

    thread_zero_a: assert property ((i_psr_num == ESR_EXC_NONE) |=> o_ics.act == 6'h00)
        else $error("active field not zero in thread mode");

    // Compared with the controller-side sources, not the register's own next value
    write_ignore_a: assert property ((i_wr && i_addr == ESR_OFS_ICS) |=>
        (o_ics.pend == $past(best) && o_ics.retb == !$past(others_actv) && o_ics.act == $past(i_psr_num)))
        else $error("write disturbed status fields");

    ics_read_a: assert property (s_ics_read |-> s_ics_data)
        else $error("status read data wrong");

endmodule : esr_readback

// [bench/esr_readback_tb.sv]
// Self-checking bench for the exception state readback block.
// Assumes esr_pkg is compiled first; the bench drives every input port itself.
`timescale 1ns/1ps

module esr_readback_tb;
    import esr_pkg::*;
    //--------------------------------------------------------
    // Signals
    //--------------------------------------------------------
    logic i_clk_sys; // 50 ns period
    logic i_rst; // Active high
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [63:0] i_exc_pend;
    logic [63:0] i_exc_enab;
    logic [63:0] i_exc_actv;
    logic [63:0][2:0] i_exc_prio;
    logic [5:0] i_psr_num;
    esr_ics_s o_ics;
    // Staging copies, edited freely, then applied once per edge
    logic [63:0] s_pend, s_enab, s_actv;
    logic [63:0][2:0] s_prio;
    logic [5:0] s_psr;
    int n_errors, samples_checked, cycles;
    logic [31:0] d;

    esr_readback u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_exc_pend(i_exc_pend), .i_exc_enab(i_exc_enab),
        .i_exc_actv(i_exc_actv), .i_exc_prio(i_exc_prio), .i_psr_num(i_psr_num), .o_ics(o_ics));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // Hang guard: the whole run needs far fewer cycles than this
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            end_of_test();
        end
    end

    //--------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd

    task automatic clr();
        s_pend = '0;
        s_enab = '0;
        s_actv = '0;
        s_prio = '0;
        s_psr = 6'h00;
    endtask : clr

    // Apply staged state, let it land, check port and register view
    task automatic look(input logic [5:0] p, input logic r, input logic [5:0] a);
        @(posedge i_clk_sys);
        i_exc_pend <= s_pend;
        i_exc_enab <= s_enab;
        i_exc_actv <= s_actv;
        i_exc_prio <= s_prio;
        i_psr_num <= s_psr;
        repeat (2) @(posedge i_clk_sys);
        #1 chk({19'h0, o_ics}, {19'h0, p, r, a});
        rd(ESR_OFS_ICS, d);
        chk(d, {14'h0, p, r, 5'h00, a});
    endtask : look

    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    //--------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------
    task automatic t_codes();
        logic [5:0] ok[10] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h0F, 6'h10, 6'h3B};
        logic [5:0] bad[5] = '{6'h01, 6'h07, 6'h0C, 6'h0D, 6'h3C};
        foreach (ok[i]) begin
            clr();
            s_pend[ok[i]] = 1'b1;
            s_enab[ok[i]] = 1'b1;
            look(ok[i], 1'b1, 6'h00);
        end
        foreach (bad[i]) begin
            clr();
            s_pend[bad[i]] = 1'b1;
            s_enab[bad[i]] = 1'b1;
            look(6'h00, 1'b1, 6'h00);
        end
    endtask : t_codes

    task automatic t_prio();
        clr();
        s_pend[18:16] = 3'b111;
        s_enab[17:16] = 2'b11;
        s_prio[16] = 3'd3;
        s_prio[17] = 3'd1;
        look(6'h11, 1'b1, 6'h00);
        s_prio[17] = 3'd3;
        look(6'h10, 1'b1, 6'h00);
        s_pend[2] = 1'b1;
        look(6'h02, 1'b1, 6'h00);
    endtask : t_prio

    // Threshold hides low-urgency levels; fault mask leaves only the NMI
    task automatic t_mask();
        wr(ESR_OFS_MASK, 32'h0000_0040);
        rd(ESR_OFS_MASK, d);
        chk(d, 32'h0000_0040);
        clr();
        s_pend[17:16] = 2'b11;
        s_enab[17:16] = 2'b11;
        s_prio[16] = 3'd1;
        s_prio[17] = 3'd2;
        look(6'h10, 1'b1, 6'h00);
        s_prio[16] = 3'd2;
        look(6'h00, 1'b1, 6'h00);
        wr(ESR_OFS_MASK, 32'h0000_0001);
        s_pend[3] = 1'b1;
        look(6'h00, 1'b1, 6'h00);
        s_pend[2] = 1'b1;
        look(6'h02, 1'b1, 6'h00);
        wr(ESR_OFS_MASK, 32'h0000_0000);
    endtask : t_mask

    task automatic t_active();
        clr();
        s_psr = 6'h12;
        s_actv[18] = 1'b1;
        look(6'h00, 1'b1, 6'h12);
        chk(32'(o_ics.act) - 32'(ESR_VEC_BASE), 32'd2);
        s_actv[17] = 1'b1;
        look(6'h00, 1'b0, 6'h12);
        s_actv[17] = 1'b0;
        s_actv[3] = 1'b1;
        look(6'h00, 1'b1, 6'h12);
        s_actv[15] = 1'b1;
        s_pend[16] = 1'b1;
        s_enab[16] = 1'b1;
        look(6'h10, 1'b0, 6'h12);
        wr(ESR_OFS_ICS, 32'hFFFF_FFFF);
        look(6'h10, 1'b0, 6'h12);
        rd(8'h08, d);
        chk(d, 32'h0000_0000);
        clr();
        look(6'h00, 1'b1, 6'h00);
    endtask : t_active

    initial begin
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_exc_pend = '0;
        i_exc_enab = '0;
        i_exc_actv = '0;
        i_exc_prio = '0;
        i_psr_num = 6'h00;
        n_errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (8) @(posedge i_clk_sys);
        chk({19'h0, o_ics}, {19'h0, 6'h00, 1'b1, 6'h00});
        chk(o_rdata, 32'h0000_0000);
        i_rst <= 1'b0;
        t_codes();
        t_prio();
        t_mask();
        t_active();
        end_of_test();
    end
endmodule : esr_readback_tb
